// ===== hw/power_alarm_cfg.svh
// Purpose: Offsets, reset values and field layouts of the power-mode and alarm registers
// Assumes: 15-bit register addresses, 8-bit register data
// Notes: Definitions only
`ifndef POWER_ALARM_CFG_SVH
`define POWER_ALARM_CFG_SVH

// ***************************************************
// Register offsets
// ***************************************************
`define ADDR_POWER_SETTING_B 15'h029a
`define ADDR_POWER_SETTING_C 15'h029b
`define ADDR_POWER_SETTING_D 15'h029c
`define ADDR_ALARM_SUMMARY 15'h02c0
`define ADDR_ALARM_EVENT_FLAGS 15'h02c1
`define ADDR_ALARM_MASK_BITS 15'h02c2
`define ADDR_STATUS_PIN_SELECT 15'h02cf

// ***************************************************
// Reset values
// ***************************************************
`define RESET_POWER_SETTING_B 8'h0f
`define RESET_POWER_SETTING_C 8'h04
`define RESET_POWER_SETTING_D 8'h1b
`define RESET_ALARM_FLAGS 6'h3f
`define RESET_ALARM_MASK 8'h3f
`define RESET_STATUS_PIN_SELECT 1'h0

// ***************************************************
// Mode codes
// ***************************************************
`define CODE_B_LOW 8'h06
`define CODE_B_HIGH 8'h0f
`define CODE_C_LOW 8'h00
`define CODE_C_HIGH 8'h04
`define CODE_D_LOW 8'h14
`define CODE_D_HIGH 8'h1b

// ***************************************************
// Field layouts
// ***************************************************
`define ALARM_HW_BITS 6'h3d
`define ALARM_REALIGN_BIT 2
`define SERIAL_FRAME_BITS 5'h18
`define SERIAL_HEADER_BITS 5'h10
`define SERIAL_LAST_HEADER_BIT 5'h0f
`define SERIAL_LAST_BIT 5'h17

`endif

// ===== hw/power_alarm_pkg.sv
// Purpose: Types shared by the power-mode and alarm register bank
// Assumes: Constants live in power_alarm_cfg.svh
// Notes: None
package power_alarm_pkg;

	// Combined operating mode seen from the three setting registers
	typedef enum logic [1:0] {
		MODE_LOW,
		MODE_HIGH,
		MODE_RESERVED
	} power_mode_t;

endpackage

// ===== hw/sync_2ff.sv
// Purpose: Two flip-flop synchroniser for pin inputs
// Assumes: Inputs are asynchronous to clk
// Notes: First stage is read only by the second stage
`timescale 1ns/10ps

module sync_2ff #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic [W-1:0] asyncIn,
	output logic [W-1:0] syncOut
);

	logic [W-1:0] stage1;
	logic [W-1:0] next_stage1;
	logic [W-1:0] next_syncOut;

	// Next values of both stages
	always_comb begin
		next_stage1 = asyncIn;
		next_syncOut = stage1;
	end

	// Metastability guard
	always_ff @(posedge clk) begin
		if (reset) begin
			stage1 <= '0;
			syncOut <= '0;
		end else begin
			stage1 <= next_stage1;
			syncOut <= next_syncOut;
		end
	end

endmodule

// ===== hw/power_alarm_regs.sv
// Purpose: Power-mode setting registers and alarm summary behind the serial control port
// Assumes: Serial port mode 0, 24-bit frames, clk much faster than the serial clock
// Notes: Frame is read flag, 15-bit address, 8 data bits, most significant first
`timescale 1ns/10ps
`include "power_alarm_cfg.svh"

module power_alarm_regs (
	input wire logic clk,
	input wire logic reset,
	input wire logic serialClk,
	input wire logic serialSelectN,
	input wire logic serialDataIn,
	input wire logic [5:0] alarmEvent,
	output logic serialDataOut,
	output logic serialDataOutEn,
	output logic statusOutputPin,
	output power_alarm_pkg::power_mode_t powerMode
);

	// ***************************************************
	// Pin synchronisation
	// ***************************************************
	logic [2:0] pinSync;
	logic sclkS;
	logic selNS;
	logic sdiS;

	sync_2ff #(.W(3)) u_pin_sync (
		.clk(clk),
		.reset(reset),
		.asyncIn({serialClk, serialSelectN, serialDataIn}),
		.syncOut(pinSync)
	);

	assign sclkS = pinSync[2];
	assign selNS = pinSync[1];
	assign sdiS = pinSync[0];

	// ***************************************************
	// Serial frame engine
	// ***************************************************
	logic sclkPrev, next_sclkPrev;
	logic [4:0] bitCnt, next_bitCnt;
	logic [14:0] shiftIn, next_shiftIn;
	logic cmdRead, next_cmdRead;
	logic [14:0] cmdAddr, next_cmdAddr;
	logic [7:0] outShift, next_outShift;
	logic next_serialDataOut, next_serialDataOutEn;
	logic wrStrobe;
	logic [7:0] wrData;
	logic rise, fall;

	logic [7:0] powerB, powerC, powerD, maskBits;
	logic [5:0] flags;
	logic summary, pinSelect;

	// Register read mux, unmapped places and bits above the summary, flags and pin select fields read zero
	function automatic logic [7:0] readMux(input logic [14:0] a, input logic [7:0] b, input logic [7:0] c,
		input logic [7:0] d, input logic s, input logic [5:0] f, input logic [7:0] m, input logic p);
		logic [7:0] r;
		r = 8'h00;
		case (a)
			`ADDR_POWER_SETTING_B: r = b;
			`ADDR_POWER_SETTING_C: r = c;
			`ADDR_POWER_SETTING_D: r = d;
			`ADDR_ALARM_SUMMARY: r = {7'h00, s};
			`ADDR_ALARM_EVENT_FLAGS: r = {2'h0, f};
			`ADDR_ALARM_MASK_BITS: r = m;
			`ADDR_STATUS_PIN_SELECT: r = {7'h00, p};
			default: r = 8'h00;
		endcase
		return r;
	endfunction

	assign rise = sclkS & ~sclkPrev;
	assign fall = ~sclkS & sclkPrev;

	// Shift in on rising edges, shift read data out on falling edges
	always_comb begin
		next_sclkPrev = sclkS;
		next_bitCnt = bitCnt;
		next_shiftIn = shiftIn;
		next_cmdRead = cmdRead;
		next_cmdAddr = cmdAddr;
		next_outShift = outShift;
		next_serialDataOut = serialDataOut;
		next_serialDataOutEn = 1'b0;
		wrStrobe = 1'b0;
		wrData = {shiftIn[6:0], sdiS};
		if (selNS) begin
			// Deselect aborts any partial frame, nothing is written
			next_bitCnt = 5'h00;
			next_serialDataOut = 1'b0;
		end else begin
			next_serialDataOutEn = cmdRead && (bitCnt >= `SERIAL_HEADER_BITS);
			if (rise && bitCnt < `SERIAL_FRAME_BITS) begin
				next_bitCnt = bitCnt + 5'h01;
				next_shiftIn = {shiftIn[13:0], sdiS};
				if (bitCnt == `SERIAL_LAST_HEADER_BIT) begin
					// Shifter is as wide as the address, so the read flag is taken before the last address bit pushes it out
					next_cmdRead = shiftIn[14];
					next_cmdAddr = {shiftIn[13:0], sdiS};
					next_outShift = readMux(next_cmdAddr, powerB, powerC, powerD, summary, flags, maskBits,
						pinSelect);
				end
				wrStrobe = (bitCnt == `SERIAL_LAST_BIT) && !cmdRead;
			end else if (fall && cmdRead && bitCnt >= `SERIAL_HEADER_BITS) begin
				next_serialDataOut = outShift[7];
				next_outShift = {outShift[6:0], 1'b0};
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			sclkPrev <= 1'b0;
			bitCnt <= 5'h00;
			shiftIn <= 15'h0000;
			cmdRead <= 1'b0;
			cmdAddr <= 15'h0000;
			outShift <= 8'h00;
			serialDataOut <= 1'b0;
			serialDataOutEn <= 1'b0;
		end else begin
			sclkPrev <= next_sclkPrev;
			bitCnt <= next_bitCnt;
			shiftIn <= next_shiftIn;
			cmdRead <= next_cmdRead;
			cmdAddr <= next_cmdAddr;
			outShift <= next_outShift;
			serialDataOut <= next_serialDataOut;
			serialDataOutEn <= next_serialDataOutEn;
		end
	end

	// ***************************************************
	// Register bank
	// ***************************************************
	logic [7:0] next_powerB, next_powerC, next_powerD, next_maskBits;
	logic [5:0] next_flags, clearBits;
	logic next_summary, next_pinSelect, next_statusOutputPin;
	logic unmaskedAny;
	power_alarm_pkg::power_mode_t next_powerMode;
	logic lowB, lowC, lowD, highB, highC, highD;

	// Any reserved code in any register makes the combined mode reserved
	always_comb begin
		lowB = (powerB == `CODE_B_LOW);
		highB = (powerB == `CODE_B_HIGH);
		lowC = (powerC == `CODE_C_LOW);
		highC = (powerC == `CODE_C_HIGH);
		lowD = (powerD == `CODE_D_LOW);
		highD = (powerD == `CODE_D_HIGH);
		if (lowB && lowC && lowD) begin
			next_powerMode = power_alarm_pkg::MODE_LOW;
		end else if (highB && highC && highD) begin
			next_powerMode = power_alarm_pkg::MODE_HIGH;
		end else begin
			next_powerMode = power_alarm_pkg::MODE_RESERVED;
		end
	end

	// Writes, flag set and clear, summary
	always_comb begin
		next_powerB = powerB;
		next_powerC = powerC;
		next_powerD = powerD;
		next_maskBits = maskBits;
		next_pinSelect = pinSelect;
		clearBits = 6'h00;
		if (wrStrobe) begin
			case (cmdAddr)
				`ADDR_POWER_SETTING_B: next_powerB = wrData;
				`ADDR_POWER_SETTING_C: next_powerC = wrData;
				`ADDR_POWER_SETTING_D: next_powerD = wrData;
				`ADDR_ALARM_EVENT_FLAGS: clearBits = wrData[5:0];
				`ADDR_ALARM_MASK_BITS: next_maskBits = wrData;
				`ADDR_STATUS_PIN_SELECT: next_pinSelect = wrData[0];
				default: clearBits = 6'h00;
			endcase
		end
		// Set wins over a clear landing in the same cycle
		next_flags = (flags & ~clearBits) | (alarmEvent & `ALARM_HW_BITS);
		// Reserved flag never reaches the summary
		unmaskedAny = |(flags & ~maskBits[5:0] & `ALARM_HW_BITS);
		next_summary = unmaskedAny;
		next_statusOutputPin = pinSelect & unmaskedAny;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			powerB <= `RESET_POWER_SETTING_B;
			powerC <= `RESET_POWER_SETTING_C;
			powerD <= `RESET_POWER_SETTING_D;
			maskBits <= `RESET_ALARM_MASK;
			flags <= `RESET_ALARM_FLAGS;
			pinSelect <= `RESET_STATUS_PIN_SELECT;
			summary <= 1'b0;
			statusOutputPin <= 1'b0;
			powerMode <= power_alarm_pkg::MODE_HIGH;
		end else begin
			powerB <= next_powerB;
			powerC <= next_powerC;
			powerD <= next_powerD;
			maskBits <= next_maskBits;
			flags <= next_flags;
			pinSelect <= next_pinSelect;
			summary <= next_summary;
			statusOutputPin <= next_statusOutputPin;
			powerMode <= next_powerMode;
		end
	end

	// ***************************************************
	// Assertions
	// ***************************************************
	property p_codeB;
		@(posedge clk) disable iff (reset)
		(powerB != `CODE_B_LOW && powerB != `CODE_B_HIGH) |=> powerMode == power_alarm_pkg::MODE_RESERVED;
	endproperty
	a_codeB: assert property (p_codeB) else $error("reserved b code not flagged");

	property p_codeC;
		@(posedge clk) disable iff (reset)
		(powerC != `CODE_C_LOW && powerC != `CODE_C_HIGH) |=> powerMode == power_alarm_pkg::MODE_RESERVED;
	endproperty
	a_codeC: assert property (p_codeC) else $error("reserved c code not flagged");

	property p_codeLow;
		@(posedge clk) disable iff (reset)
		(powerB == `CODE_B_LOW && powerC == `CODE_C_LOW && powerD == `CODE_D_LOW)
			|=> powerMode == power_alarm_pkg::MODE_LOW;
	endproperty
	a_codeLow: assert property (p_codeLow) else $error("low codes not decoded");

	property p_resetHigh;
		@(posedge clk) disable iff (reset)
		$past(reset) |-> (powerB == `CODE_B_HIGH && powerC == `CODE_C_HIGH && powerD == `CODE_D_HIGH
			&& maskBits == `RESET_ALARM_MASK && flags == `RESET_ALARM_FLAGS);
	endproperty
	a_resetHigh: assert property (p_resetHigh) else $error("wrong reset values");

	property p_summary;
		@(posedge clk) disable iff (reset)
		##1 summary == $past(|(flags & ~maskBits[5:0] & `ALARM_HW_BITS));
	endproperty
	a_summary: assert property (p_summary) else $error("summary does not match flags");

	property p_masked;
		@(posedge clk) disable iff (reset)
		((maskBits[5:0] & `ALARM_HW_BITS) == `ALARM_HW_BITS) [*2] |-> !summary;
	endproperty
	a_masked: assert property (p_masked) else $error("masked alarm reached summary");

	property p_pin;
		@(posedge clk) disable iff (reset)
		##1 statusOutputPin == ($past(pinSelect) && summary);
	endproperty
	a_pin: assert property (p_pin) else $error("status pin disagrees with summary");

	property p_realign;
		@(posedge clk) disable iff (reset)
		alarmEvent[`ALARM_REALIGN_BIT] |=> flags[`ALARM_REALIGN_BIT];
	endproperty
	a_realign: assert property (p_realign) else $error("realignment flag lost");

	property p_clear;
		@(posedge clk) disable iff (reset)
		(wrStrobe && cmdAddr == `ADDR_ALARM_EVENT_FLAGS && wrData[0] && !alarmEvent[0]) |=> !flags[0] ##1 (!summary
			|| maskBits[5:2] != 4'hf);
	endproperty
	a_clear: assert property (p_clear) else $error("write one did not clear flag");

endmodule

// ===== tb/power_alarm_regs_tb.sv
// Purpose: Self-checking bench for the power-mode and alarm register bank
// Assumes: Serial port mode 0, serialClk halves of HALF clk periods
// Notes: Mode rows run in one loop; reset values are checked before it, alarm and mid-run reset cases are written out after it
`timescale 1ns/10ps
`include "power_alarm_cfg.svh"

module power_alarm_regs_tb;
	localparam int HALF = 6;
	localparam int LIMIT = 60000;
	typedef struct {
		logic [7:0] b;
		logic [7:0] c;
		logic [7:0] d;
		power_alarm_pkg::power_mode_t mode;
	} case_row_t;

	logic clk, reset, serialClk, serialSelectN, serialDataIn;
	logic [5:0] alarmEvent;
	logic serialDataOut, serialDataOutEn, statusOutputPin;
	power_alarm_pkg::power_mode_t powerMode;
	logic [7:0] rd;
	int nFail = 0;
	int numChecks = 0;
	int cycles = 0;
	case_row_t rows [9];

	power_alarm_regs dut (
		.clk(clk),
		.reset(reset),
		.serialClk(serialClk),
		.serialSelectN(serialSelectN),
		.serialDataIn(serialDataIn),
		.alarmEvent(alarmEvent),
		.serialDataOut(serialDataOut),
		.serialDataOutEn(serialDataOutEn),
		.statusOutputPin(statusOutputPin),
		.powerMode(powerMode)
	);

	// ****************************************
	// Clock and hang guard
	// ****************************************
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// A stuck frame counts as a failure, not a silent hang
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == LIMIT) begin
			nFail = nFail + 1;
			summarize();
		end
	end

	// ****************************************
	// Helpers
	// ****************************************
	// Inputs always change 1 ns after the rising edge
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic checkByte(input string what, input logic [7:0] exp, input logic [7:0] got);
		numChecks++;
		if (got !== exp) begin
			nFail++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic checkBit(input string what, input logic exp, input logic got);
		numChecks++;
		if (got !== exp) begin
			nFail++;
			$display("ERROR %s expected %b seen %b", what, exp, got);
		end
	endtask

	task automatic checkMode(input power_alarm_pkg::power_mode_t exp);
		numChecks++;
		if (powerMode !== exp) begin
			nFail++;
			$display("ERROR powerMode expected %s seen %s", exp.name(), powerMode.name());
		end
	endtask

	// One 24-bit frame, MSB first; read bits are taken just before each rise
	task automatic xfer(input logic isRead, input logic [14:0] addr, input logic [7:0] wd, output logic [7:0] q);
		logic [23:0] word;
		word = {isRead, addr, wd};
		q = 8'h00;
		serialSelectN = 1'b0;
		tick(3);
		for (int i = 23; i >= 0; i--) begin
			serialDataIn = word[i];
			tick(HALF);
			if (isRead && i < 8) begin
				q[i] = serialDataOut;
			end
			// Output enable only for the data phase of reads
			if (i == 0) begin
				checkBit("serialDataOutEn", isRead, serialDataOutEn);
			end
			serialClk = 1'b1;
			tick(HALF);
			serialClk = 1'b0;
		end
		tick(HALF);
		serialSelectN = 1'b1;
		// Released line must not keep showing the last bit
		serialDataIn = ~serialDataIn;
		tick(4);
		checkBit("serialDataOutEn idle", 1'b0, serialDataOutEn);
	endtask

	task automatic writeReg(input logic [14:0] addr, input logic [7:0] wd);
		logic [7:0] unused;
		xfer(1'b0, addr, wd, unused);
	endtask

	task automatic readCheck(input string what, input logic [14:0] addr, input logic [7:0] exp);
		xfer(1'b1, addr, 8'h00, rd);
		checkByte(what, exp, rd);
	endtask

	task automatic pulse(input logic [5:0] v);
		alarmEvent = v;
		tick(1);
		alarmEvent = 6'h00;
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", numChecks, nFail);
		if (nFail == 0 && numChecks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		// Mixed rows break host discipline on purpose to reach the reserved decode
		rows = '{
			'{8'h06, 8'h00, 8'h14, power_alarm_pkg::MODE_LOW},
			'{8'h0f, 8'h04, 8'h1b, power_alarm_pkg::MODE_HIGH},
			'{8'h06, 8'h04, 8'h1b, power_alarm_pkg::MODE_RESERVED},
			'{8'h0f, 8'h00, 8'h1b, power_alarm_pkg::MODE_RESERVED},
			'{8'h0f, 8'h04, 8'h14, power_alarm_pkg::MODE_RESERVED},
			'{8'h07, 8'h04, 8'h1b, power_alarm_pkg::MODE_RESERVED},
			'{8'h06, 8'h00, 8'h15, power_alarm_pkg::MODE_RESERVED},
			'{8'h0f, 8'h05, 8'h1b, power_alarm_pkg::MODE_RESERVED},
			'{8'h0f, 8'h04, 8'h1b, power_alarm_pkg::MODE_HIGH}
		};
		reset = 1'b1;
		serialClk = 1'b0;
		serialSelectN = 1'b1;
		serialDataIn = 1'b0;
		alarmEvent = 6'h00;
		tick(12);
		reset = 1'b0;
		tick(3);
		// Reset state
		checkMode(power_alarm_pkg::MODE_HIGH);
		readCheck("settingB", `ADDR_POWER_SETTING_B, 8'h0f);
		readCheck("settingC", `ADDR_POWER_SETTING_C, 8'h04);
		readCheck("settingD", `ADDR_POWER_SETTING_D, 8'h1b);
		readCheck("flags", `ADDR_ALARM_EVENT_FLAGS, 8'h3f);
		readCheck("mask", `ADDR_ALARM_MASK_BITS, 8'h3f);
		readCheck("summary", `ADDR_ALARM_SUMMARY, 8'h00);
		checkBit("statusOutputPin", 1'b0, statusOutputPin);
		$display("test reset values done");
		// Mode code rows
		// Enables are taken as already off and the rate within the low-power limit;
		// recalibration after each row is the host's job outside this bank
		foreach (rows[i]) begin
			writeReg(`ADDR_POWER_SETTING_B, rows[i].b);
			writeReg(`ADDR_POWER_SETTING_C, rows[i].c);
			writeReg(`ADDR_POWER_SETTING_D, rows[i].d);
			checkMode(rows[i].mode);
			readCheck("settingB", `ADDR_POWER_SETTING_B, rows[i].b);
			readCheck("settingC", `ADDR_POWER_SETTING_C, rows[i].c);
			readCheck("settingD", `ADDR_POWER_SETTING_D, rows[i].d);
		end
		$display("test mode rows done");
		// Read-only summary and an unmapped place
		writeReg(`ADDR_ALARM_SUMMARY, 8'hff);
		readCheck("summary", `ADDR_ALARM_SUMMARY, 8'h00);
		writeReg(15'h0123, 8'h5a);
		readCheck("unmapped", 15'h0123, 8'h00);
		$display("test read-only done");
		// Unmask clock alarm and route summary to the pin
		writeReg(`ADDR_STATUS_PIN_SELECT, 8'h01);
		writeReg(`ADDR_ALARM_MASK_BITS, 8'h3e);
		readCheck("summary", `ADDR_ALARM_SUMMARY, 8'h01);
		checkBit("statusOutputPin", 1'b1, statusOutputPin);
		writeReg(`ADDR_ALARM_EVENT_FLAGS, 8'h01);
		readCheck("flags", `ADDR_ALARM_EVENT_FLAGS, 8'h3e);
		checkBit("statusOutputPin", 1'b0, statusOutputPin);
		writeReg(`ADDR_ALARM_EVENT_FLAGS, 8'h3f);
		readCheck("flags", `ADDR_ALARM_EVENT_FLAGS, 8'h00);
		// Event to pin takes exactly two edges
		pulse(6'h01);
		checkBit("statusOutputPin", 1'b0, statusOutputPin);
		tick(1);
		checkBit("statusOutputPin", 1'b1, statusOutputPin);
		pulse(6'h04);
		tick(2);
		readCheck("flags", `ADDR_ALARM_EVENT_FLAGS, 8'h05);
		writeReg(`ADDR_ALARM_EVENT_FLAGS, 8'h01);
		readCheck("summary", `ADDR_ALARM_SUMMARY, 8'h00);
		writeReg(`ADDR_ALARM_MASK_BITS, 8'h3a);
		readCheck("summary", `ADDR_ALARM_SUMMARY, 8'h01);
		writeReg(`ADDR_STATUS_PIN_SELECT, 8'h00);
		checkBit("statusOutputPin", 1'b0, statusOutputPin);
		$display("test alarm summary done");
		// Mid-run reset restores settings and flags
		writeReg(`ADDR_POWER_SETTING_B, 8'h06);
		reset = 1'b1;
		tick(3);
		reset = 1'b0;
		tick(3);
		checkMode(power_alarm_pkg::MODE_HIGH);
		readCheck("settingB", `ADDR_POWER_SETTING_B, 8'h0f);
		readCheck("flags", `ADDR_ALARM_EVENT_FLAGS, 8'h3f);
		readCheck("mask", `ADDR_ALARM_MASK_BITS, 8'h3f);
		$display("test mid-run reset done");
		summarize();
	end
endmodule
